//--- dcpo_top.sv
// dual compare pulse output channel: register port, two time bases, pulse engine
// assumes a plain register port on ref_clk; the compare pin drives outside logic
`timescale 1ns/1ps
`default_nettype none
module dcpo_top
  import dcpo_pkg::*;
(
  input  wire logic                        ref_clk,
  input  wire logic                        resetn,
  input  wire logic [dcpo_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [dcpo_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_write,
  input  wire logic                        reg_read,
  output var  logic [dcpo_pkg::DATA_W-1:0] reg_rdata,
  output var  logic                        compare_output_pin,
  output var  logic                        compare_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  logic wr_compare_control;
  logic wr_primary;
  logic wr_secondary;
  logic wr_irq_status;
  logic wr_t0_control;
  logic wr_t0_count;
  logic wr_t0_period;
  logic wr_t1_control;
  logic wr_t1_count;
  logic wr_t1_period;

  assign wr_compare_control = reg_write && (reg_addr == OFF_COMPARE_CONTROL);
  assign wr_primary         = reg_write && (reg_addr == OFF_PRIMARY_COMPARE);
  assign wr_secondary       = reg_write && (reg_addr == OFF_SECONDARY_COMPARE);
  assign wr_irq_status      = reg_write && (reg_addr == OFF_IRQ_STATUS);
  assign wr_t0_control      = reg_write && (reg_addr == OFF_T0_CONTROL);
  assign wr_t0_count        = reg_write && (reg_addr == OFF_T0_COUNT);
  assign wr_t0_period       = reg_write && (reg_addr == OFF_T0_PERIOD);
  assign wr_t1_control      = reg_write && (reg_addr == OFF_T1_CONTROL);
  assign wr_t1_count        = reg_write && (reg_addr == OFF_T1_COUNT);
  assign wr_t1_period       = reg_write && (reg_addr == OFF_T1_PERIOD);

  ////////////////////////////////////////////////////////////////////////////
  // compare registers

  logic [MODE_W-1:0]  compare_mode_sel_r;
  logic               timebase_select_r;
  logic [DATA_W-1:0]  primary_compare_r;
  logic [DATA_W-1:0]  secondary_compare_r;
  logic               compare_irq_enable_r;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      compare_mode_sel_r   <= 3'h0;
      timebase_select_r    <= 1'b0;
      primary_compare_r    <= RST_WORD;
      secondary_compare_r  <= RST_WORD;
      compare_irq_enable_r <= 1'b0;
    end
    else
    begin
      if (wr_compare_control)
      begin
        compare_mode_sel_r <= reg_wdata[MODE_LSB +: MODE_W]; // R1
        timebase_select_r  <= reg_wdata[TBSEL_BIT]; // R11
      end
      if (wr_primary)
        primary_compare_r <= reg_wdata;
      if (wr_secondary)
        secondary_compare_r <= reg_wdata;
      if (wr_irq_status)
        compare_irq_enable_r <= reg_wdata[IRQ_EN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // time bases

  logic              t0_on;
  logic [DATA_W-1:0] t0_count;
  logic [DATA_W-1:0] t0_period;
  logic              t0_stepped;
  logic              t1_on;
  logic [DATA_W-1:0] t1_count;
  logic [DATA_W-1:0] t1_period;
  logic              t1_stepped;

  dcpo_timebase u_timebase0
  (
    .ref_clk      (ref_clk),
    .resetn       (resetn),
    .wr_control   (wr_t0_control),
    .wr_count     (wr_t0_count),
    .wr_period    (wr_t0_period),
    .wdata        (reg_wdata),
    .timer_on     (t0_on),
    .timer_count  (t0_count),
    .timer_period (t0_period),
    .stepped      (t0_stepped)
  );

  dcpo_timebase u_timebase1
  (
    .ref_clk      (ref_clk),
    .resetn       (resetn),
    .wr_control   (wr_t1_control),
    .wr_count     (wr_t1_count),
    .wr_period    (wr_t1_period),
    .wdata        (reg_wdata),
    .timer_on     (t1_on),
    .timer_count  (t1_count),
    .timer_period (t1_period),
    .stepped      (t1_stepped)
  );

  logic [DATA_W-1:0] timer_count;
  logic              timer_stepped;
  logic              match_primary;
  logic              match_secondary;

  assign timer_count   = timebase_select_r ? t1_count : t0_count; // R11
  assign timer_stepped = timebase_select_r ? t1_stepped : t0_stepped;

  // only a fresh count matches, so a stopped or just-loaded count of zero
  // does not fire until the time base has wrapped onto it
  assign match_primary   = timer_stepped && (timer_count == primary_compare_r); // R2 R21
  assign match_secondary = timer_stepped && (timer_count == secondary_compare_r); // R3 R21

  ////////////////////////////////////////////////////////////////////////////
  // pulse engine

  logic        dual_mode;
  logic        cont_mode;
  logic        arm_write;
  dcpo_state_t state_r;
  dcpo_state_t state_nxt;
  logic        pin_r;
  logic        pin_nxt;
  logic        fall_event;

  assign cont_mode = (compare_mode_sel_r == MODE_CONT_PULSE);
  assign dual_mode = (compare_mode_sel_r == MODE_SINGLE_PULSE) || cont_mode; // R1
  // any write of a dual mode code re-arms, even if the code is unchanged
  assign arm_write = wr_compare_control &&
                     ((reg_wdata[MODE_LSB +: MODE_W] == MODE_SINGLE_PULSE) ||
                      (reg_wdata[MODE_LSB +: MODE_W] == MODE_CONT_PULSE)); // R15

  assign fall_event = (state_r == ST_WAIT_FALL) && match_secondary && !wr_compare_control;

  always_comb
  begin
    state_nxt = state_r;
    pin_nxt   = pin_r;
    if (wr_compare_control)
    begin
      state_nxt = arm_write ? ST_WAIT_RISE : ST_IDLE; // R15
      pin_nxt   = 1'b0; // R5
    end
    else if (!dual_mode)
    begin
      state_nxt = ST_IDLE;
      pin_nxt   = 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          state_nxt = ST_IDLE;
          pin_nxt   = 1'b0;
        end
        ST_WAIT_RISE:
        begin
          // a primary compare above the period never matches, pin stays low
          if (match_primary) // R19
          begin
            state_nxt = ST_WAIT_FALL;
            pin_nxt   = 1'b1; // R6
          end
        end
        ST_WAIT_FALL:
        begin
          // secondary beyond the period never matches, pin holds high
          if (match_secondary) // R9
          begin
            state_nxt = cont_mode ? ST_WAIT_RISE : ST_DONE; // R18 R7
            pin_nxt   = 1'b0; // R3
          end
        end
        ST_DONE:
        begin
          state_nxt = ST_DONE; // R13
          pin_nxt   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      pin_r   <= 1'b0; // R20
    end
    else
    begin
      state_r <= state_nxt;
      pin_r   <= pin_nxt;
    end
  end

  assign compare_output_pin = pin_r;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flag: raised two instruction clocks after the pin falls

  logic [FLAG_DELAY_CYC-1:0] fall_pipe_r;
  logic                    compare_irq_flag_r;
  logic                    flag_set;
  logic                    flag_clear;

  // the flag flop adds the last clock, so the tap sits one stage early
  assign flag_set   = fall_pipe_r[FLAG_DELAY_CYC-1]; // R10
  assign flag_clear = wr_irq_status && !reg_wdata[IRQ_FLAG_BIT];

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      fall_pipe_r        <= '0;
      compare_irq_flag_r <= 1'b0;
    end
    else
    begin
      fall_pipe_r <= {fall_pipe_r[FLAG_DELAY_CYC-2:0], fall_event};
      // a set in the same cycle as a software clear wins
      if (flag_set)
        compare_irq_flag_r <= 1'b1; // R14
      else if (flag_clear)
        compare_irq_flag_r <= 1'b0;
    end
  end

  assign compare_irq = compare_irq_flag_r && compare_irq_enable_r; // R14

  ////////////////////////////////////////////////////////////////////////////
  // read port: data stand the cycle after the strobe, unmapped reads zero

  logic [DATA_W-1:0] read_mux;
  logic [DATA_W-1:0] control_view;
  logic [DATA_W-1:0] status_view;
  logic [DATA_W-1:0] t0_control_view;
  logic [DATA_W-1:0] t1_control_view;
  logic [DATA_W-1:0] reg_rdata_r;

  assign control_view    = {7'h00, pin_r, 4'h0, timebase_select_r, compare_mode_sel_r};
  assign status_view     = {14'h0000, compare_irq_enable_r, compare_irq_flag_r};
  assign t0_control_view = {t0_on, 15'h0000};
  assign t1_control_view = {t1_on, 15'h0000};

  assign read_mux = (reg_addr == OFF_COMPARE_CONTROL)   ? control_view :
                    (reg_addr == OFF_PRIMARY_COMPARE)   ? primary_compare_r :
                    (reg_addr == OFF_SECONDARY_COMPARE) ? secondary_compare_r :
                    (reg_addr == OFF_IRQ_STATUS)        ? status_view :
                    (reg_addr == OFF_T0_CONTROL)        ? t0_control_view :
                    (reg_addr == OFF_T0_COUNT)          ? t0_count :
                    (reg_addr == OFF_T0_PERIOD)         ? t0_period :
                    (reg_addr == OFF_T1_CONTROL)        ? t1_control_view :
                    (reg_addr == OFF_T1_COUNT)          ? t1_count :
                    (reg_addr == OFF_T1_PERIOD)         ? t1_period : RST_WORD;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata_r <= RST_WORD;
    else if (reg_read)
      reg_rdata_r <= read_mux;
    else
      reg_rdata_r <= RST_WORD;
  end

  assign reg_rdata = reg_rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_arm_drives_low: assert property (@(posedge ref_clk) disable iff (!resetn) // R5
    arm_write |=> (!compare_output_pin && state_r == ST_WAIT_RISE))
    else $error("arming write did not drive the pin low");

  a_low_before_rise: assert property (@(posedge ref_clk) disable iff (!resetn) // R5
    (state_r == ST_WAIT_RISE) |-> !compare_output_pin)
    else $error("pin high while waiting for primary match");

  a_rise_one_clock: assert property (@(posedge ref_clk) disable iff (!resetn) // R6
    (state_r == ST_WAIT_RISE && dual_mode && match_primary && !wr_compare_control)
      |=> (compare_output_pin && $rose(compare_output_pin)))
    else $error("pin did not rise one clock after primary match");

  a_fall_one_clock: assert property (@(posedge ref_clk) disable iff (!resetn) // R3
    fall_event && dual_mode |=> $fell(compare_output_pin))
    else $error("pin did not fall one clock after secondary match");

  a_high_holds: assert property (@(posedge ref_clk) disable iff (!resetn) // R9
    (state_r == ST_WAIT_FALL && !match_secondary && !wr_compare_control && dual_mode)
      |=> compare_output_pin)
    else $error("pin fell without a secondary match");

  a_flag_two_clocks: assert property (@(posedge ref_clk) disable iff (!resetn) // R10
    (fall_event && dual_mode) |=> !compare_output_pin ##2 compare_irq_flag_r)
    else $error("flag not set two clocks after pin fell");

  a_flag_needs_fall: assert property (@(posedge ref_clk) disable iff (!resetn) // R19
    $rose(compare_irq_flag_r) |-> $past(fall_event, 3))
    else $error("flag set without a preceding falling edge");

  a_done_stays_low: assert property (@(posedge ref_clk) disable iff (!resetn) // R13
    (state_r == ST_DONE && !wr_compare_control && dual_mode)
      |=> (state_r == ST_DONE && !compare_output_pin))
    else $error("single pulse produced a further edge");

  a_irq_gated: assert property (@(posedge ref_clk) disable iff (!resetn) // R14
    compare_irq |-> (compare_irq_enable_r && compare_irq_flag_r))
    else $error("interrupt request without enable");

  a_cont_rearms: assert property (@(posedge ref_clk) disable iff (!resetn) // R18
    (fall_event && cont_mode) |=> (state_r == ST_WAIT_RISE))
    else $error("continuous mode did not re-arm after fall");

endmodule
`default_nettype wire

//--- dcpo_pkg.sv
// constants, register map and state encoding for the dual compare pulse output channel
// assumes one 125 MHz clock that is also the instruction clock of the compare logic
//
// Notes on behaviour
// [R1] mode field 100 selects single pulse, 101 selects continuous pulse.
// [R2] primary compare match against the rising timer count makes the rising edge.
// [R3] secondary compare match against the same count makes the falling edge.
// [R4] software writes 100 and selects and starts the compare time base.
// [R5] on entering single pulse mode the pin is driven low until primary match.
// [R6] pin goes high one instruction clock after the primary match.
// [R7] pin stays high until secondary match, then low until mode change or disable.
// [R8] time base counts up to its period, then returns to zero next clock.
// [R9] period below secondary compare: no falling edge, pin stays high.
// [R10] interrupt flag sets two instruction clocks after the pin falls.
// [R11] control bit 3 picks which of two timers feeds the compare.
// [R12] timer control bit 15 starts the time base counting.
// [R13] after the trailing edge of a single pulse, no more pulses, pin low.
// [R14] second match sets the flag; request raised only when enable is set.
// [R15] rewriting mode 100 re-arms a new pulse without disabling first.
// [R16] software sets period at or above the secondary compare beforehand.
// [R17] software loads compares, then mode and timer select, then starts timer.
// [R18] mode 101 repeats rise and fall every period until mode change.
// [R19] primary compare above period: timer wraps first, pin low, no flag.
// [R20] reset forces the compare output logic and pin to zero.
// [R21] compares and counts are 16-bit unsigned equality tests.
package dcpo_pkg;

  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 6;

  // byte offsets of the word registers
  localparam logic [5:0] OFF_COMPARE_CONTROL   = 6'h00;
  localparam logic [5:0] OFF_PRIMARY_COMPARE   = 6'h04;
  localparam logic [5:0] OFF_SECONDARY_COMPARE = 6'h08;
  localparam logic [5:0] OFF_IRQ_STATUS        = 6'h0c;
  localparam logic [5:0] OFF_T0_CONTROL        = 6'h10;
  localparam logic [5:0] OFF_T0_COUNT          = 6'h14;
  localparam logic [5:0] OFF_T0_PERIOD         = 6'h18;
  localparam logic [5:0] OFF_T1_CONTROL        = 6'h20;
  localparam logic [5:0] OFF_T1_COUNT          = 6'h24;
  localparam logic [5:0] OFF_T1_PERIOD         = 6'h28;

  // field positions
  localparam int unsigned MODE_LSB       = 0;
  localparam int unsigned MODE_W         = 3;
  localparam int unsigned TBSEL_BIT      = 3;
  localparam int unsigned PIN_STATE_BIT  = 8;
  localparam int unsigned TIMER_ON_BIT   = 15;
  localparam int unsigned IRQ_FLAG_BIT   = 0;
  localparam int unsigned IRQ_EN_BIT     = 1;

  // mode encodings
  localparam logic [2:0] MODE_SINGLE_PULSE = 3'h4;
  localparam logic [2:0] MODE_CONT_PULSE   = 3'h5;

  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] RST_PERIOD = 16'hffff;

  // timing: instruction clocks, converted to ref_clk cycles
  localparam int unsigned CLK_PERIOD_NS     = 8;
  localparam int unsigned INSTR_CLK_NS      = 8;
  localparam int unsigned RISE_DELAY_INSTR  = 1;
  localparam int unsigned FLAG_DELAY_INSTR  = 2;
  localparam int unsigned RISE_DELAY_CYC    = RISE_DELAY_INSTR * INSTR_CLK_NS / CLK_PERIOD_NS;
  localparam int unsigned FLAG_DELAY_CYC    = FLAG_DELAY_INSTR * INSTR_CLK_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0]
  {
    ST_IDLE      = 2'b00,
    ST_WAIT_RISE = 2'b01,
    ST_WAIT_FALL = 2'b10,
    ST_DONE      = 2'b11
  } dcpo_state_t;

endpackage

//--- dcpo_timebase.sv
// one 16-bit up-counting compare time base with control, count and period
// assumes writes come from the register port of the top on the same clock
`timescale 1ns/1ps
`default_nettype none
module dcpo_timebase
  import dcpo_pkg::*;
(
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire logic                    wr_control,
  input  wire logic                    wr_count,
  input  wire logic                    wr_period,
  input  wire logic [dcpo_pkg::DATA_W-1:0] wdata,
  output var  logic                    timer_on,
  output var  logic [dcpo_pkg::DATA_W-1:0] timer_count,
  output var  logic [dcpo_pkg::DATA_W-1:0] timer_period,
  output var  logic                    stepped
);

  logic                 timer_on_r;
  logic [DATA_W-1:0]    count_r;
  logic [DATA_W-1:0]    period_r;
  logic                 stepped_r;
  logic [DATA_W-1:0]    count_nxt;
  logic                 at_period;

  assign at_period = (count_r == period_r);
  assign count_nxt = wr_count ? wdata :
                     !timer_on_r ? count_r :
                     at_period ? RST_WORD : DATA_W'(count_r + 16'h0001); // R8

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      timer_on_r <= 1'b0;
      count_r    <= RST_WORD;
      period_r   <= RST_PERIOD;
      stepped_r  <= 1'b0;
    end
    else
    begin
      if (wr_control)
        timer_on_r <= wdata[TIMER_ON_BIT]; // R12
      if (wr_period)
        period_r <= wdata;
      count_r   <= count_nxt;
      // a match counts only when the count has just moved onto its value
      stepped_r <= timer_on_r && !wr_count;
    end
  end

  assign timer_on     = timer_on_r;
  assign timer_count  = count_r;
  assign timer_period = period_r;
  assign stepped      = stepped_r;

  a_timer_wrap: assert property (@(posedge ref_clk) disable iff (!resetn) // R8
    (timer_on_r && at_period && !wr_count) |=> (count_r == 16'h0000))
    else $error("time base did not return to zero after period");

  a_timer_hold: assert property (@(posedge ref_clk) disable iff (!resetn) // R12
    (!timer_on_r && !wr_count) |=> $stable(count_r))
    else $error("stopped time base changed its count");

endmodule
`default_nettype wire

//--- dcpo_pin_recorder.sv
// edge recorder standing in for the circuitry fed by the compare pin
// assumes pin and request line change only at ref_clk rising edges
`timescale 1ns/1ps
`default_nettype none
module dcpo_pin_recorder
(
  input  wire logic ref_clk,
  input  wire logic pin,
  input  wire logic irq,
  output var  int   cyc,
  output var  int   rise_n,
  output var  int   fall_n,
  output var  int   irq_n,
  output var  int   rise_at,
  output var  int   prev_rise_at,
  output var  int   fall_at,
  output var  int   irq_at
);
  logic pin_q;
  logic irq_q;

  // sampled mid-cycle so an edge time never races the clock edge that made it
  initial
  begin
    {cyc, rise_n, fall_n, irq_n, rise_at, prev_rise_at, fall_at, irq_at} = '0;
    pin_q = 1'b0;
    irq_q = 1'b0;
    forever
    begin
      @(negedge ref_clk);
      if (pin === 1'b1 && pin_q !== 1'b1)
      begin
        prev_rise_at = rise_at;
        rise_at = cyc;
        rise_n++;
      end
      if (pin === 1'b0 && pin_q === 1'b1)
      begin
        fall_at = cyc;
        fall_n++;
      end
      if (irq === 1'b1 && irq_q !== 1'b1)
      begin
        irq_at = cyc;
        irq_n++;
      end
      pin_q = pin;
      irq_q = irq;
      cyc++;
    end
  end
endmodule
`default_nettype wire

//--- dcpo_top_tb.sv
// self-checking bench for the dual compare pulse output channel
// assumes the register port of dcpo_top and one 125 MHz clock
`timescale 1ns/1ps
`default_nettype none
module dcpo_top_tb;
  import dcpo_pkg::*;

  logic              ref_clk;
  logic              resetn;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic              reg_write;
  logic              reg_read;
  wire  [DATA_W-1:0] reg_rdata;
  wire               compare_output_pin;
  wire               compare_irq;
  int                cyc, rise_n, fall_n, irq_n, rise_at, prev_rise_at, fall_at, irq_at;
  int                fails, checks, st, r0, f0, i0;
  logic [2:0]        bad [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h6, 3'h7};

  dcpo_top i_dut (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .compare_output_pin(compare_output_pin), .compare_irq(compare_irq));

  dcpo_pin_recorder i_recorder (.ref_clk(ref_clk), .pin(compare_output_pin), .irq(compare_irq),
    .cyc(cyc), .rise_n(rise_n), .fall_n(fall_n), .irq_n(irq_n), .rise_at(rise_at),
    .prev_rise_at(prev_rise_at), .fall_at(fall_at), .irq_at(irq_at));

  ////////////////////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error at %0t ns: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask

  task automatic rchk(input logic [5:0] a, input logic [15:0] exp, input string what);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    @(negedge ref_clk);
    chk(reg_rdata, exp, what);
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic wait_pin(input logic lvl);
    int n;
    n = 0;
    while (compare_output_pin !== lvl && n < 40)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk(compare_output_pin, lvl, "pin level reached");
  endtask

  // timer stopped and cleared first so the start edge is a known time origin
  task automatic arm(input logic [5:0] tb, input logic [15:0] ctl, input logic [15:0] pri,
                     input logic [15:0] sec, input logic [15:0] per);
    wr(tb, 16'h0000);
    wr(OFF_PRIMARY_COMPARE, pri);
    wr(OFF_SECONDARY_COMPARE, sec);
    wr(tb + 6'h08, per);
    wr(tb + 6'h04, 16'h0000);
    wr(OFF_COMPARE_CONTROL, ctl);
    r0 = rise_n;
    f0 = fall_n;
    i0 = irq_n;
    wr(tb, 16'h8000);
    st = cyc;
  endtask

  task automatic reset_vals();
    chk(compare_output_pin, 1'b0, "pin after reset");
    chk(compare_irq, 1'b0, "request after reset");
    rchk(OFF_COMPARE_CONTROL, 16'h0000, "control reset");
    rchk(OFF_T0_PERIOD, 16'hffff, "t0 period reset");
    rchk(OFF_T1_PERIOD, 16'hffff, "t1 period reset");
    rchk(OFF_T1_COUNT, 16'h0000, "t1 count reset");
    rchk(OFF_IRQ_STATUS, 16'h0000, "status reset");
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  initial
  begin
    #(8 * 20000);
    fails++;
    summarize();
  end

  initial
  begin
    fails = 0;
    checks = 0;
    resetn = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    reset_vals();
    wr(6'h3c, 16'hffff);
    rchk(6'h3c, 16'h0000, "unmapped place");
    // plain single pulse on timer 0
    wr(OFF_IRQ_STATUS, 16'h0002);
    arm(OFF_T0_CONTROL, 16'h0004, 16'h0002, 16'h0004, 16'h0005);
    settle(30);
    chk(rise_at, st + 3, "rise time");
    chk(fall_at, st + 5, "fall time");
    chk(irq_at, fall_at + 2, "request delay");
    chk(rise_n - r0, 1, "single rise");
    chk(compare_output_pin, 1'b0, "low after pulse");
    rchk(OFF_IRQ_STATUS, 16'h0003, "flag set");
    rchk(OFF_COMPARE_CONTROL, 16'h0004, "pin state bit low");
    wr(OFF_IRQ_STATUS, 16'h0002);
    rchk(OFF_IRQ_STATUS, 16'h0002, "flag cleared");
    // re-arm with the timer left running
    r0 = rise_n;
    wr(OFF_COMPARE_CONTROL, 16'h0004);
    settle(14);
    chk(rise_n - r0, 1, "re-armed rise");
    chk(fall_at - rise_at, 2, "re-armed width");
    // request masked
    wr(OFF_IRQ_STATUS, 16'h0000);
    i0 = irq_n;
    wr(OFF_COMPARE_CONTROL, 16'h0004);
    settle(14);
    chk(irq_n - i0, 0, "masked request");
    rchk(OFF_IRQ_STATUS, 16'h0001, "flag while masked");
    // timer 1 selected, fall after wrap
    arm(OFF_T1_CONTROL, 16'h000c, 16'h0004, 16'h0001, 16'h0005);
    settle(20);
    chk(rise_at, st + 5, "timer 1 rise");
    chk(fall_at, st + 8, "fall after wrap");
    // secondary above period
    wr(OFF_IRQ_STATUS, 16'h0000);
    arm(OFF_T1_CONTROL, 16'h000c, 16'h0002, 16'h0009, 16'h0005);
    settle(20);
    chk(compare_output_pin, 1'b1, "stays high");
    chk(fall_n - f0, 0, "no fall");
    rchk(OFF_COMPARE_CONTROL, 16'h010c, "pin state bit high");
    rchk(OFF_IRQ_STATUS, 16'h0000, "no flag");
    wr(OFF_SECONDARY_COMPARE, 16'h0004);
    settle(14);
    chk(fall_n - f0, 1, "fall once in range");
    chk(compare_output_pin, 1'b0, "low once in range");
    // continuous pulses
    arm(OFF_T0_CONTROL, 16'h0005, 16'h0001, 16'h0003, 16'h0005);
    settle(30);
    chk(rise_at - prev_rise_at, 6, "pulse repeat");
    chk(fall_at - rise_at, 2, "pulse width");
    chk(rise_n - r0 > 3, 1, "several pulses");
    // modes that are not dual compare
    foreach (bad[k])
    begin
      wr(OFF_COMPARE_CONTROL, {13'h0000, bad[k]});
      settle(2);
      r0 = rise_n;
      settle(12);
      chk(rise_n - r0, 0, "idle mode rise");
      chk(compare_output_pin, 1'b0, "idle mode pin");
    end
    // primary above period
    wr(OFF_IRQ_STATUS, 16'h0000);
    arm(OFF_T0_CONTROL, 16'h0004, 16'h0009, 16'h0004, 16'h0005);
    settle(20);
    chk(rise_n - r0, 0, "no rise");
    rchk(OFF_IRQ_STATUS, 16'h0000, "no flag");
    // mode change and reset while high
    arm(OFF_T1_CONTROL, 16'h000d, 16'h0002, 16'h0009, 16'h0005);
    wait_pin(1'b1);
    settle(3);
    chk(compare_output_pin, 1'b1, "continuous stays high");
    wr(OFF_COMPARE_CONTROL, 16'h0000);
    settle(2);
    chk(compare_output_pin, 1'b0, "low on mode change");
    wr(OFF_COMPARE_CONTROL, 16'h000d);
    wait_pin(1'b1);
    @(posedge ref_clk);
    resetn <= 1'b0;
    #1;
    chk(compare_output_pin, 1'b0, "low in reset");
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    reset_vals();
    summarize();
  end
endmodule
`default_nettype wire
